// ---- verilog/gauge_regs.svh ----
// register indices, field positions, reset values and timing counts of the gauge core
// assumes a 50 MHz core clock; included by bare name
`ifndef GAUGE_REGS_SVH
`define GAUGE_REGS_SVH
`define IDX_STATUS 3'h0
`define IDX_CTRL 3'h1
`define IDX_CHG_MSB 3'h2
`define IDX_CHG_LSB 3'h3
`define IDX_THR_HI_MSB 3'h4
`define IDX_THR_HI_LSB 3'h5
`define IDX_THR_LO_MSB 3'h6
`define IDX_THR_LO_LSB 3'h7
`define CTRL_RESET 8'h3c
`define CHG_RESET 16'h7fff
`define THR_HI_RESET 16'hffff
`define THR_LO_RESET 16'h0000
`define CHG_FULL 16'hffff
`define CHG_EMPTY 16'h0000
`define CTRL_PRESC_MSB 5
`define CTRL_PRESC_LSB 3
`define CTRL_PIN_MSB 2
`define CTRL_PIN_LSB 1
`define CTRL_SHDN 0
`define CHIP_ID_BIT 1'h1
`define BUS_ADDR 7'h64
`define ALERT_RESP_ADDR 7'h0c
`define AXI_OKAY 2'h0
`define AXI_SLVERR 2'h2
`define CLK_PERIOD_NS 20
`define CHARGE_DONE_MIN_PULSE_NS 1000
`define CHARGE_DONE_MIN_PULSE_CYC \
   ((`CHARGE_DONE_MIN_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// ---- verilog/gauge_pkg.sv ----
// types shared by the gauge core files
// assumes nothing beyond a SystemVerilog compiler
package gauge_pkg;
   // multi-purpose pin role, as held in the control register
   typedef enum logic [1:0]
   {
      PIN_OFF = 2'b00,
      PIN_CHG_DONE = 2'b01,
      PIN_ALERT = 2'b10,
      PIN_BAD = 2'b11
   } pin_mode_t;

   // serial slave states, one-hot
   typedef enum logic [6:0]
   {
      SER_IDLE = 7'b0000001,
      SER_ADDR = 7'b0000010,
      SER_AACK = 7'b0000100,
      SER_WR = 7'b0001000,
      SER_WACK = 7'b0010000,
      SER_RD = 7'b0100000,
      SER_RACK = 7'b1000000
   } ser_state_t;
endpackage : gauge_pkg

// ---- verilog/pin_sync.sv ----
// three-flop sampler for levels from outside the core clock domain
// assumes inputs change slower than a few core clock periods
module pin_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
)
(
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic [WIDTH-1:0] i_async,
   output logic [WIDTH-1:0] o_level
);
   logic [WIDTH-1:0] s1_reg;
   logic [WIDTH-1:0] s2_reg;
   logic [WIDTH-1:0] s3_reg;

   // first stage feeds only the second stage
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         s1_reg <= RESET_VAL;
         s2_reg <= RESET_VAL;
         s3_reg <= RESET_VAL;
      end
      else
      begin
         s1_reg <= i_async;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
      end
   end

   // a change counts once stages two and three agree
   for (genvar g = 0; g < WIDTH; g++)
   begin : g_bit
      always_ff @(posedge i_clk or negedge i_rst_n)
      begin
         if (!i_rst_n)
            o_level[g] <= RESET_VAL[g];
         else if (s2_reg[g] == s3_reg[g])
            o_level[g] <= s3_reg[g];
      end
   end
endmodule : pin_sync

// ---- verilog/coulomb_counter_digital_core.sv ----
// digital core of a charge gauge: prescaler, saturating count, limits, pin, buses
// assumes one 50 MHz clock; serial bus, pin and integrator inputs are asynchronous
// Operation
// R1 - charge-done mode with pin high forces count to all ones
// R2 - the charger holds a charge-done pulse at least the minimum width
// R3 - pin role comes from the two-bit pin field of control
// R4 - pin starts in alert mode and answers the alert response address
// R5 - alert mode pulls pin low while a limit flag stands
// R6 - count direction comes from switch state and ramp direction
// R7 - reversal events pass a prescaler of factor 1 to 128
// R8 - prescaler overflow adds one, underflow subtracts one
// R9 - one count equals 0.085 mAh times factor over 128
// R10 - reset loads all defaults with the counter running
// R11 - reset count mid-scale, low limit zeros, high limit ones
// R12 - reset selects alert mode and factor 128
// R13 - serial slave answers only its fixed seven-bit address; the code also acks the alert response address on reads while pulling the pin
// R14 - slave only: clock is input, data line is two-way
// R15 - standard and fast bus rates up to 400 kHz
// R16 - count saturates at all ones or all zeros
// R17 - count compared with both limits sets high or low flag
// R18 - pin field 10 alert, 01 charge-done, 00 off, 11 illegal
// R19 - prescaler factor is two to the power of its field
// R20 - charge-done input is synchronised before use
// R21 - charge-done preset takes priority over counting
`include "gauge_regs.svh"
module coulomb_counter_digital_core
   import gauge_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic [5:0] i_awaddr,
   input wire logic i_awvalid,
   output logic o_awready,
   input wire logic [31:0] i_wdata,
   input wire logic [3:0] i_wstrb,
   input wire logic i_wvalid,
   output logic o_wready,
   output logic [1:0] o_bresp,
   output logic o_bvalid,
   input wire logic i_bready,
   input wire logic [5:0] i_araddr,
   input wire logic i_arvalid,
   output logic o_arready,
   output logic [31:0] o_rdata,
   output logic [1:0] o_rresp,
   output logic o_rvalid,
   input wire logic i_rready,
   input wire logic i_scl,
   input wire logic i_sda,
   output logic o_sda,
   output logic o_sda_oe_n,
   input wire logic i_alert_or_charge_done_pin,
   output logic o_alert_or_charge_done_pin,
   output logic o_alert_or_charge_done_pin_oe_n,
   input wire logic i_ramp_reversal,
   input wire logic i_switch_state,
   input wire logic i_ramp_dir,
   output logic [15:0] o_accumulated_charge_count
);
   logic [5:0] sync_lvl;
   logic scl, sda, pin_lvl, rev_lvl, sw_lvl, dir_lvl;
   logic scl_q, sda_q, rev_q;
   logic [7:0] ctrl_reg;
   logic [15:0] chg_reg, thr_hi_reg, thr_lo_reg;
   logic st_rail_reg, st_high_reg, st_low_reg, ara_mute_reg;
   logic [6:0] presc_reg, presc_max;
   pin_mode_t pin_mode;
   logic cd_active, ev, charge_up, ovf, unf, rd_status, any_flag;
   logic wr_en;
   logic [2:0] wr_idx;
   logic [7:0] wr_data;
   logic aw_hold_reg, aw_bad_reg, w_hold_reg, w_strb0_reg, bvalid_reg, rvalid_reg;
   logic [2:0] aw_idx_reg;
   logic [7:0] w_data_reg;
   logic [1:0] bresp_reg, rresp_reg;
   logic [31:0] rdata_reg;
   logic axi_wr_done, axi_rd_fire;
   ser_state_t ser_state;
   logic [3:0] bit_cnt;
   logic [7:0] shift_reg, tx_byte;
   logic rw_reg, first_reg, ara_reg, sda_oe_n_reg;
   logic ser_wr_reg, ser_rd_st_reg, ara_ans_reg;
   logic [2:0] ser_idx_reg, ptr_reg;
   logic [7:0] ser_data_reg;
   logic scl_rise, scl_fall, bus_start, bus_stop, pin_pull_reg;
   logic [5:0] cd_run_cnt;

   // all asynchronous inputs share one sampler; bus lines idle high.
   // 20 ns sampling leaves many samples per 400 kHz bit
   pin_sync #(.WIDTH(6), .RESET_VAL(6'h30)) u_sync ( // R15 R20 R2
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_async({i_scl, i_sda, i_alert_or_charge_done_pin, i_ramp_reversal,
                i_switch_state, i_ramp_dir}),
      .o_level(sync_lvl)
   );
   assign {scl, sda, pin_lvl, rev_lvl, sw_lvl, dir_lvl} = sync_lvl;

   // previous levels for edge finding
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
         rev_q <= 1'b0;
      end
      else
      begin
         scl_q <= scl;
         sda_q <= sda;
         rev_q <= rev_lvl;
      end
   end

   // byte view of the register map, shared by both buses
   function automatic logic [7:0] reg_read(input logic [2:0] idx);
      unique case (idx)
         `IDX_STATUS: reg_read = {`CHIP_ID_BIT, 1'b0, st_rail_reg, 1'b0, st_high_reg,
                                  st_low_reg, 2'b00};
         `IDX_CTRL: reg_read = ctrl_reg;
         `IDX_CHG_MSB: reg_read = chg_reg[15:8];
         `IDX_CHG_LSB: reg_read = chg_reg[7:0];
         `IDX_THR_HI_MSB: reg_read = thr_hi_reg[15:8];
         `IDX_THR_HI_LSB: reg_read = thr_hi_reg[7:0];
         `IDX_THR_LO_MSB: reg_read = thr_lo_reg[15:8];
         `IDX_THR_LO_LSB: reg_read = thr_lo_reg[7:0];
      endcase
   endfunction : reg_read

   // only aligned words of the eight registers are mapped
   function automatic logic addr_bad(input logic [5:0] a);
      addr_bad = (a[1:0] != 2'b00) || a[5];
   endfunction : addr_bad

   // pin role, charge-done preset and event qualification
   assign pin_mode = pin_mode_t'(ctrl_reg[`CTRL_PIN_MSB:`CTRL_PIN_LSB]); // R3 R18
   assign cd_active = (pin_mode == PIN_CHG_DONE) && pin_lvl; // R1 R18
   assign presc_max = 7'((8'h01 << ctrl_reg[`CTRL_PRESC_MSB:`CTRL_PRESC_LSB]) - 8'h01); // R19
   assign charge_up = (sw_lvl == dir_lvl); // R6
   // shutdown drops events; an active preset swallows them too
   assign ev = rev_lvl && !rev_q && !ctrl_reg[`CTRL_SHDN] && !cd_active; // R6 R21
   assign ovf = ev && charge_up && (presc_reg >= presc_max); // R7
   assign unf = ev && !charge_up && (presc_reg == 7'h00); // R7

   // prescaler: one count is 0.085 mAh scaled by factor over 128
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         presc_reg <= 7'h00;
      else if (ev && charge_up)
         presc_reg <= ovf ? 7'h00 : 7'(presc_reg + 7'h01); // R7 R9
      else if (ev)
         presc_reg <= unf ? presc_max : 7'(presc_reg - 7'h01); // R7 R9
   end

   // shared write port; serial writes cannot stall so they win
   assign axi_wr_done = aw_hold_reg && w_hold_reg && !bvalid_reg && !ser_wr_reg;
   always_comb
   begin
      wr_en = ser_wr_reg;
      wr_idx = ser_idx_reg;
      wr_data = ser_data_reg;
      if (axi_wr_done && !aw_bad_reg && w_strb0_reg)
      begin
         wr_en = 1'b1;
         wr_idx = aw_idx_reg;
         wr_data = w_data_reg;
      end
   end

   // accumulated count: preset, then writes, then saturating steps
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         chg_reg <= `CHG_RESET; // R10 R11
      else if (cd_active)
         chg_reg <= `CHG_FULL; // R1 R21
      else if (wr_en && wr_idx == `IDX_CHG_MSB)
         chg_reg[15:8] <= wr_data;
      else if (wr_en && wr_idx == `IDX_CHG_LSB)
         chg_reg[7:0] <= wr_data;
      else if (ovf && chg_reg != `CHG_FULL)
         chg_reg <= 16'(chg_reg + 16'h0001); // R8 R16
      else if (unf && chg_reg != `CHG_EMPTY)
         chg_reg <= 16'(chg_reg - 16'h0001); // R8 R16
   end
   assign o_accumulated_charge_count = chg_reg;

   // control and limit registers
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         ctrl_reg <= `CTRL_RESET; // R4 R10 R12
         thr_hi_reg <= `THR_HI_RESET; // R11
         thr_lo_reg <= `THR_LO_RESET; // R11
      end
      else if (wr_en)
      begin
         unique case (wr_idx)
            `IDX_CTRL: ctrl_reg <= wr_data;
            `IDX_THR_HI_MSB: thr_hi_reg[15:8] <= wr_data;
            `IDX_THR_HI_LSB: thr_hi_reg[7:0] <= wr_data;
            `IDX_THR_LO_MSB: thr_lo_reg[15:8] <= wr_data;
            `IDX_THR_LO_LSB: thr_lo_reg[7:0] <= wr_data;
            default: ;
         endcase
      end
   end

   // sticky flags: a standing condition beats a clearing read
   assign rd_status = ser_rd_st_reg || (axi_rd_fire && !addr_bad(i_araddr) &&
                      i_araddr[4:2] == `IDX_STATUS);
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         st_rail_reg <= 1'b0;
         st_high_reg <= 1'b0;
         st_low_reg <= 1'b0;
      end
      else
      begin
         st_rail_reg <= (chg_reg == `CHG_FULL) || (chg_reg == `CHG_EMPTY) ||
                        (st_rail_reg && !rd_status); // R16
         st_high_reg <= (chg_reg > thr_hi_reg) || (st_high_reg && !rd_status); // R17
         st_low_reg <= (chg_reg < thr_lo_reg) || (st_low_reg && !rd_status); // R17
      end
   end
   assign any_flag = st_rail_reg || st_high_reg || st_low_reg;

   // alert pin; an answered alert response silences it until flags clear
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         ara_mute_reg <= 1'b0;
         pin_pull_reg <= 1'b0;
      end
      else
      begin
         ara_mute_reg <= any_flag && (ara_mute_reg || ara_ans_reg); // R4
         pin_pull_reg <= (pin_mode == PIN_ALERT) && any_flag && !ara_mute_reg; // R5
      end
   end
   // open drain: only ever drives low
   assign o_alert_or_charge_done_pin = 1'b0;
   assign o_alert_or_charge_done_pin_oe_n = !pin_pull_reg; // R5

   // axi write: address and data taken in either order
   assign o_awready = !aw_hold_reg;
   assign o_wready = !w_hold_reg;
   assign o_bvalid = bvalid_reg;
   assign o_bresp = bresp_reg;
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         aw_hold_reg <= 1'b0;
         aw_bad_reg <= 1'b0;
         aw_idx_reg <= 3'h0;
         w_hold_reg <= 1'b0;
         w_strb0_reg <= 1'b0;
         w_data_reg <= 8'h00;
         bvalid_reg <= 1'b0;
         bresp_reg <= `AXI_OKAY;
      end
      else
      begin
         if (i_awvalid && !aw_hold_reg)
         begin
            aw_hold_reg <= 1'b1;
            aw_bad_reg <= addr_bad(i_awaddr);
            aw_idx_reg <= i_awaddr[4:2];
         end
         if (i_wvalid && !w_hold_reg)
         begin
            w_hold_reg <= 1'b1;
            w_strb0_reg <= i_wstrb[0];
            w_data_reg <= i_wdata[7:0];
         end
         if (axi_wr_done)
         begin
            aw_hold_reg <= 1'b0;
            w_hold_reg <= 1'b0;
            bvalid_reg <= 1'b1;
            bresp_reg <= aw_bad_reg ? `AXI_SLVERR : `AXI_OKAY;
         end
         else if (bvalid_reg && i_bready)
            bvalid_reg <= 1'b0;
      end
   end

   // axi read: one cycle from address to data
   assign o_arready = !rvalid_reg;
   assign axi_rd_fire = i_arvalid && !rvalid_reg;
   assign o_rvalid = rvalid_reg;
   assign o_rdata = rdata_reg;
   assign o_rresp = rresp_reg;
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h0000_0000;
         rresp_reg <= `AXI_OKAY;
      end
      else if (axi_rd_fire)
      begin
         rvalid_reg <= 1'b1;
         rdata_reg <= addr_bad(i_araddr) ? 32'h0000_0000 : {24'h00_0000, reg_read(i_araddr[4:2])};
         rresp_reg <= addr_bad(i_araddr) ? `AXI_SLVERR : `AXI_OKAY;
      end
      else if (rvalid_reg && i_rready)
         rvalid_reg <= 1'b0;
   end

   // serial bus events seen on the sampled lines; clock is input only
   assign scl_rise = scl && !scl_q; // R14
   assign scl_fall = !scl && scl_q;
   assign bus_start = scl && scl_q && sda_q && !sda;
   assign bus_stop = scl && scl_q && !sda_q && sda;
   assign tx_byte = ara_reg ? {`BUS_ADDR, 1'b0} : reg_read(ptr_reg);
   assign o_sda = 1'b0;
   assign o_sda_oe_n = sda_oe_n_reg; // R14

   // serial slave: bits taken on clock rise, driven after clock fall
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         ser_state <= SER_IDLE;
         bit_cnt <= 4'h0;
         shift_reg <= 8'h00;
         rw_reg <= 1'b0;
         first_reg <= 1'b0;
         ara_reg <= 1'b0;
         ptr_reg <= 3'h0;
         sda_oe_n_reg <= 1'b1;
         ser_wr_reg <= 1'b0;
         ser_idx_reg <= 3'h0;
         ser_data_reg <= 8'h00;
         ser_rd_st_reg <= 1'b0;
         ara_ans_reg <= 1'b0;
      end
      else
      begin
         ser_wr_reg <= 1'b0;
         ser_rd_st_reg <= 1'b0;
         ara_ans_reg <= 1'b0;
         if (bus_stop)
         begin
            ser_state <= SER_IDLE;
            sda_oe_n_reg <= 1'b1;
         end
         else if (bus_start)
         begin
            ser_state <= SER_ADDR;
            bit_cnt <= 4'h0;
            first_reg <= 1'b1;
            sda_oe_n_reg <= 1'b1;
         end
         else
         begin
            unique case (ser_state)
               SER_IDLE: ;
               SER_ADDR, SER_WR:
               begin
                  if (scl_rise)
                  begin
                     shift_reg <= {shift_reg[6:0], sda};
                     bit_cnt <= 4'(bit_cnt + 4'h1);
                  end
                  else if (scl_fall && bit_cnt == 4'h8 && ser_state == SER_ADDR)
                  begin
                     rw_reg <= shift_reg[0];
                     ara_reg <= shift_reg[7:1] != `BUS_ADDR;
                     if (shift_reg[7:1] == `BUS_ADDR || (shift_reg[7:1] ==
                         `ALERT_RESP_ADDR && shift_reg[0] && pin_pull_reg)) // R13 R4
                     begin
                        sda_oe_n_reg <= 1'b0;
                        ser_state <= SER_AACK;
                     end
                     else
                        ser_state <= SER_IDLE;
                  end
                  else if (scl_fall && bit_cnt == 4'h8)
                  begin
                     sda_oe_n_reg <= 1'b0;
                     ser_state <= SER_WACK;
                     first_reg <= 1'b0;
                     if (first_reg)
                        ptr_reg <= shift_reg[2:0];
                     else
                     begin
                        ser_wr_reg <= 1'b1;
                        ser_idx_reg <= ptr_reg;
                        ser_data_reg <= shift_reg;
                        ptr_reg <= 3'(ptr_reg + 3'h1);
                     end
                  end
               end
               SER_AACK:
                  if (scl_fall && rw_reg)
                  begin
                     // the first bit goes out with the ack release
                     sda_oe_n_reg <= tx_byte[7];
                     shift_reg <= {tx_byte[6:0], 1'b0};
                     bit_cnt <= 4'h1;
                     ara_ans_reg <= ara_reg;
                     ser_rd_st_reg <= !ara_reg && ptr_reg == `IDX_STATUS;
                     ser_state <= SER_RD;
                  end
                  else if (scl_fall)
                  begin
                     sda_oe_n_reg <= 1'b1;
                     bit_cnt <= 4'h0;
                     ser_state <= SER_WR;
                  end
               SER_WACK:
                  if (scl_fall)
                  begin
                     sda_oe_n_reg <= 1'b1;
                     bit_cnt <= 4'h0;
                     ser_state <= SER_WR;
                  end
               SER_RD:
                  if (scl_fall && bit_cnt == 4'h8)
                  begin
                     sda_oe_n_reg <= 1'b1;
                     ser_state <= SER_RACK;
                  end
                  else if (scl_fall)
                  begin
                     sda_oe_n_reg <= shift_reg[7];
                     shift_reg <= {shift_reg[6:0], 1'b0};
                     bit_cnt <= 4'(bit_cnt + 4'h1);
                  end
               SER_RACK:
                  if (scl_rise && sda)
                     ser_state <= SER_IDLE;
                  else if (scl_rise)
                  begin
                     ptr_reg <= ara_reg ? ptr_reg : 3'(ptr_reg + 3'h1);
                     ara_reg <= 1'b0;
                     ser_state <= SER_AACK;
                  end
               default:
                  ser_state <= SER_IDLE;
            endcase
         end
      end
   end

   // helper: cycles the raw pin has stood high in charge-done mode
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         cd_run_cnt <= 6'h00;
      else if (pin_mode != PIN_CHG_DONE || !i_alert_or_charge_done_pin)
         cd_run_cnt <= 6'h00;
      else if (cd_run_cnt != 6'(`CHARGE_DONE_MIN_PULSE_CYC))
         cd_run_cnt <= 6'(cd_run_cnt + 6'h01);
   end

   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_rst_n);

   sequence s_overflow_step;
      ovf && !cd_active && !wr_en;
   endsequence
   sequence s_underflow_step;
      unf && !cd_active && !wr_en;
   endsequence
   sequence s_own_addr_done;
      ser_state == SER_ADDR && scl_fall && bit_cnt == 4'h8 && shift_reg[7:1] == `BUS_ADDR;
   endsequence

   a_cd_within_pulse: assert property ( // R1
      cd_run_cnt == 6'(`CHARGE_DONE_MIN_PULSE_CYC) |-> chg_reg == `CHG_FULL)
      else $error("count not preset within charge-done pulse");
   a_cd_preset_wins: assert property (cd_active |=> chg_reg == `CHG_FULL && // R21
      $stable(presc_reg)) else $error("counting went on during preset");
   a_pin_not_alert: assert property (pin_mode != PIN_ALERT |=> // R3
      o_alert_or_charge_done_pin_oe_n) else $error("pin driven outside alert mode");
   a_alert_pulls: assert property (pin_mode == PIN_ALERT && any_flag && !ara_mute_reg // R5
      |=> !o_alert_or_charge_done_pin_oe_n) else $error("alert pin not pulled");
   a_count_up: assert property (s_overflow_step ##0 chg_reg != `CHG_FULL // R8
      |=> chg_reg == 16'($past(chg_reg) + 16'h0001)) else $error("overflow not counted");
   a_count_down: assert property (s_underflow_step ##0 chg_reg != `CHG_EMPTY // R8
      |=> chg_reg == 16'($past(chg_reg) - 16'h0001)) else $error("underflow not counted");
   a_sat_top: assert property (s_overflow_step ##0 chg_reg == `CHG_FULL // R16
      |=> chg_reg == `CHG_FULL) else $error("count wrapped at top");
   a_sat_bottom: assert property (s_underflow_step ##0 chg_reg == `CHG_EMPTY // R16
      |=> chg_reg == `CHG_EMPTY) else $error("count wrapped at bottom");
   a_presc_reload: assert property (unf |=> presc_reg == $past(presc_max)) // R7
      else $error("prescaler reload wrong");
   a_high_flag: assert property (chg_reg > thr_hi_reg |=> st_high_reg ##1 // R17
      (st_high_reg || chg_reg <= thr_hi_reg)) else $error("high flag missed");
   a_addr_ack: assert property (s_own_addr_done |=> !o_sda_oe_n) // R13
      else $error("own address not acknowledged");
endmodule : coulomb_counter_digital_core

// ---- dv/serial_host_model.sv ----
// serial bus host model: start, one address byte, acknowledge sample, stop
// assumes the bench resolves the data line with a pull-up
module serial_host_model
(
   input wire logic i_sda,
   output logic o_scl = 1'b1,
   output logic o_sda = 1'b1
);
   timeunit 1ns;
   timeprecision 1ns;

   // clock stands high between frames; only this side makes clock edges
   task automatic frame(input logic [6:0] addr, output logic ack);
      logic [8:0] b;
      b = {addr, 1'b0, 1'b1}; // last bit released for the acknowledge
      // bus free time first; the offset also keeps edges off the core clock
      #1305 o_sda = 1'b0;
      #80 o_scl = 1'b0;
      for (int i = 8; i >= 0; i--)
      begin
         #40 o_sda = b[i];
         #40 o_scl = 1'b1;
         #40 ack = !i_sda; // halfway through the high phase, slave drives after fall
         #40 o_scl = 1'b0;
      end
      #40 o_sda = 1'b0;
      #40 o_scl = 1'b1;
      #80 o_sda = 1'b1;
   endtask : frame
endmodule : serial_host_model

// ---- dv/tb_coulomb_counter_digital_core.sv ----
// self-checking bench of the gauge core: register bus, counting, pin, serial address
// assumes the serial host model and the gauge header are on the include path
`include "gauge_regs.svh"
module tb_coulomb_counter_digital_core;
   timeunit 1ns;
   timeprecision 1ns;
   logic i_clk = 1'b0, i_rst_n = 1'b0, i_scl, m_sda, pin_drv = 1'b1, hold = 1'b0;
   logic [5:0] i_awaddr = '0, i_araddr = '0;
   logic [31:0] i_wdata = '0;
   logic [3:0] i_wstrb = 4'h1;
   logic i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b1, i_arvalid = 1'b0, i_rready = 1'b1;
   logic i_ramp_reversal = 1'b0, i_switch_state = 1'b0, i_ramp_dir = 1'b0;
   logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_sda, o_sda_oe_n;
   logic o_alert_or_charge_done_pin, o_alert_or_charge_done_pin_oe_n;
   logic [1:0] o_bresp, o_rresp;
   logic [31:0] o_rdata;
   logic [15:0] o_accumulated_charge_count;
   // open-drain lines with pull-ups
   wire logic i_sda = m_sda & o_sda_oe_n;
   wire logic i_alert_or_charge_done_pin = pin_drv & o_alert_or_charge_done_pin_oe_n;
   int err_total = 0, total_checks = 0, cnt = 32'h7fff, pre = 0, fac = 1;
   logic [7:0] rst_tbl [8] = '{8'h80, 8'h3c, 8'h7f, 8'hff, 8'hff, 8'hff, 8'h00, 8'h00};
   coulomb_counter_digital_core dut (.*);
   serial_host_model host (.i_sda(i_sda), .o_scl(i_scl), .o_sda(m_sda));
   initial forever #10 i_clk = ~i_clk;

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         err_total++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic wrap_up();
      if (err_total == 0 && total_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : wrap_up

   // ready is sampled mid-cycle, released right after the edge that took it
   task automatic axi_wr(input logic [5:0] a, input logic [7:0] d, input logic [1:0] er);
      logic ta = 1'b0;
      logic tw = 1'b0;
      i_awaddr <= a;
      i_wdata <= {24'h0, d};
      i_awvalid <= 1'b1;
      i_wvalid <= 1'b1;
      while (!(ta && tw))
      begin
         @(negedge i_clk);
         ta = ta | (i_awvalid & o_awready);
         tw = tw | (i_wvalid & o_wready);
         @(posedge i_clk);
         if (ta) i_awvalid <= 1'b0;
         if (tw) i_wvalid <= 1'b0;
      end
      do @(negedge i_clk); while (o_bvalid !== 1'b1);
      chk(o_bresp, er);
      @(posedge i_clk);
   endtask : axi_wr

   task automatic rd_chk(input logic [5:0] a, input logic [7:0] e, input logic [1:0] er);
      i_araddr <= a;
      i_arvalid <= 1'b1;
      do @(negedge i_clk); while (o_arready !== 1'b1);
      @(posedge i_clk);
      i_arvalid <= 1'b0;
      do @(negedge i_clk); while (o_rvalid !== 1'b1);
      chk({o_rresp, o_rdata[7:0]}, {er, e});
      @(posedge i_clk);
   endtask : rd_chk

   // one reversal event; direction levels settle before the edge
   task automatic ev(input logic up);
      logic dr;
      dr = 1'($urandom);
      i_ramp_dir <= dr;
      i_switch_state <= dr ^ !up;
      repeat (3) @(posedge i_clk);
      i_ramp_reversal <= 1'b1;
      repeat (5) @(posedge i_clk);
      i_ramp_reversal <= 1'b0;
      repeat (6) @(posedge i_clk);
      pre = hold ? pre : up ? pre + 1 : pre - 1; // a preset swallows the event
      if (pre == fac && cnt != 32'hffff) cnt++;
      if (pre < 0 && cnt != 0) cnt--;
      pre = (pre + fac) % fac;
      if (hold) cnt = 32'hffff;
      chk(o_accumulated_charge_count, 16'(cnt));
   endtask : ev

   // main sequence
   initial
   begin
      logic ack;
      int psel;
      void'($urandom(32'hd008));
      repeat (4) @(posedge i_clk);
      i_rst_n <= 1'b1;
      @(posedge i_clk);
      for (int k = 0; k < 8; k++) rd_chk(6'(4 * k), rst_tbl[k], `AXI_OKAY);
      chk(o_alert_or_charge_done_pin_oe_n, 1'b1);
      rd_chk(6'h20, 8'h00, `AXI_SLVERR);
      axi_wr(6'h22, 8'h00, `AXI_SLVERR);
      host.frame(7'h65, ack);
      chk(ack, 1'b0);
      host.frame(7'h64, ack);
      chk(ack, 1'b1);
      chk({o_sda, o_alert_or_charge_done_pin}, 2'b00);
      axi_wr(6'h10, 8'h00, `AXI_OKAY);
      repeat (4) @(posedge i_clk);
      chk(o_alert_or_charge_done_pin_oe_n, 1'b0);
      axi_wr(6'h10, 8'hff, `AXI_OKAY);
      rd_chk(6'h00, 8'h88, `AXI_OKAY);
      repeat (4) @(posedge i_clk);
      chk(o_alert_or_charge_done_pin_oe_n, 1'b1);
      psel = $urandom % 8;
      fac = 1 << psel;
      axi_wr(6'h04, {2'b00, 3'(psel), 3'b100}, `AXI_OKAY);
      rd_chk(6'h04, {2'b00, 3'(psel), 3'b100}, `AXI_OKAY);
      repeat (4 + $urandom % 8) ev(1'($urandom));
      axi_wr(6'h08, 8'hff, `AXI_OKAY);
      axi_wr(6'h0c, 8'hff, `AXI_OKAY);
      cnt = 32'hffff;
      repeat (fac + 1) ev(1'b1);
      rd_chk(6'h00, 8'ha0, `AXI_OKAY);
      repeat (fac) ev(1'b0);
      pin_drv <= 1'b0;
      axi_wr(6'h04, {2'b00, 3'(psel), 3'b010}, `AXI_OKAY);
      chk(o_accumulated_charge_count, 16'(cnt));
      pin_drv <= 1'b1; // pulse well over the minimum width
      hold = 1'b1;
      repeat (8) @(posedge i_clk);
      chk(o_accumulated_charge_count, 16'hffff);
      ev(1'b0);
      repeat (40) @(posedge i_clk);
      pin_drv <= 1'b0;
      repeat (6) @(posedge i_clk);
      chk(o_accumulated_charge_count, 16'hffff);
      hold = 1'b0;
      repeat (fac) ev(1'b0);
      wrap_up();
   end

   // hang guard, far beyond the expected run
   initial
   begin
      #400000;
      err_total++;
      wrap_up();
   end
endmodule : tb_coulomb_counter_digital_core
